// file: pkg/rxs_pkg.sv
// Package for the receiver error status flag block.
// Assumes an 8-bit register port with 7-bit register addresses.
package rxs_pkg;

  // Register addresses
  localparam logic [6:0] RXS_ADDR_ERR_STATUS = 7'h14;
  localparam logic [6:0] RXS_ADDR_SLIP_STATUS = 7'h15;
  localparam logic [6:0] RXS_ADDR_ERR_MASK = 7'h16;
  localparam logic [6:0] RXS_ADDR_SLIP_MASK = 7'h17;
  localparam logic [6:0] RXS_ADDR_SUBCODE_FIRST = 7'h1f;
  localparam logic [6:0] RXS_ADDR_SUBCODE_LAST = 7'h28;

  // Field positions in the error and slip status registers
  localparam int RXS_BIT_CS_CRC = 7;
  localparam int RXS_BIT_PARITY = 6;
  localparam int RXS_BIT_VALIDITY = 5;
  localparam int RXS_BIT_BIPHASE = 4;
  localparam int RXS_BIT_SUBCODE_CHG = 3;
  localparam int RXS_BIT_UNLOCK = 2;
  localparam int RXS_BIT_SUBCODE_CRC = 1;
  localparam int RXS_BIT_BUF_DONE = 0;
  localparam int RXS_BIT_SLIP = 0;

  // Reset values
  localparam logic [7:0] RXS_RST_MASK = 8'h00;
  localparam logic [7:0] RXS_RST_STATUS = 8'h00;
  localparam logic [7:0] RXS_RST_LOCK_STATUS = 8'h04;

  // Serial port source and mode
  typedef struct packed {
    logic src_rx_a;
    logic src_rx_b;
    logic slave_a;
    logic slave_b;
    logic slip_a;
    logic slip_b;
  } rxs_port_t;

  // Receiver events, one-cycle pulses except the levels
  typedef struct packed {
    logic cs_crc_err;
    logic parity_err;
    logic validity;
    logic biphase_err;
    logic subcode_new;
    logic decoder_locked;
    logic pll_locked;
    logic subcode_crc_err;
    logic copy_done;
  } rxs_event_t;

endpackage

// file: hdl/rxs_sync.sv
// Two-stage synchroniser for a bus of level inputs.
// Assumes the inputs come from another clock domain or pins.
`timescale 1ns/1ps
`default_nettype none
module rxs_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage is read only by the second
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// file: hdl/rxs_flag.sv
// One sticky status flag with mask gating.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rxs_flag (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic mask_en_i,
  // Status
  output logic flag_o,
  output logic irq_o
);
  logic flag_q;

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
  assign irq_o = flag_q & mask_en_i;
endmodule
`default_nettype wire

// file: hdl/rxs_status_top.sv
// Receiver error and slip status registers with interrupt masks.
// Assumes receiver event pulses are on ref_clk_i; lock levels may be async.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Channel status, parity, biphase errors set flags
// - Bit 5 reports received validity indication
// - Subcode change sets bit 3
// - Bit 2 high while decoder or PLL unlocked
// - Subcode check failure sets bit 1
// - Buffer copy completion sets bit 0
// - Mask 0x16 gates error status interrupts
// - Mask 0x17 gates output slip interrupt
// - Slip or repeat sets slip bit 0
// - Slip only for receiver-sourced slave port
// - Both ports sourced: track port A only
// - Slip register bits 7..1 read zero
// - Masks reset to zero, one enables
// - Copy disable stops buffer copy flag
module rxs_status_top
  import rxs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Receiver events
  input wire rxs_event_t rx_evt_i,
  // Serial port configuration and slip events
  input wire rxs_port_t port_i,
  // Buffer copy control
  input wire logic buffer_copy_disable_i,
  // Interrupt request, active low
  output logic irq_n_o
);

  // Register decode
  wire rd_err_w = reg_rd_i && (reg_addr_i == RXS_ADDR_ERR_STATUS);
  wire rd_slip_w = reg_rd_i && (reg_addr_i == RXS_ADDR_SLIP_STATUS);
  wire wr_err_mask_w = reg_wr_i && (reg_addr_i == RXS_ADDR_ERR_MASK);
  wire wr_slip_mask_w = reg_wr_i && (reg_addr_i == RXS_ADDR_SLIP_MASK);

  // Mask registers
  logic [7:0] err_mask_q;
  logic [7:0] err_mask_d;
  logic slip_mask_q;
  logic slip_mask_d;

  assign err_mask_d = wr_err_mask_w ? reg_wdata_i : err_mask_q;
  assign slip_mask_d = wr_slip_mask_w ? reg_wdata_i[RXS_BIT_SLIP] : slip_mask_q;

  // Masks come up masked
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_mask_q <= RXS_RST_MASK;
      slip_mask_q <= RXS_RST_MASK[RXS_BIT_SLIP];
    end else begin
      err_mask_q <= err_mask_d;
      slip_mask_q <= slip_mask_d;
    end
  end

  // Lock levels come from the recovery loops, so synchronise them
  logic [1:0] lock_sync_w;
  rxs_sync #(
    .W(2)
  ) u_lock_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i({rx_evt_i.decoder_locked, rx_evt_i.pll_locked}),
    .q_o(lock_sync_w)
  );

  // Unlock is a live level: both must be locked to report clear
  wire unlock_w = ~(lock_sync_w[1] & lock_sync_w[0]);

  // Slip qualification: port A wins when both are sourced
  wire slip_a_ok_w = port_i.src_rx_a & port_i.slave_a;
  wire slip_b_ok_w = port_i.src_rx_b & port_i.slave_b & ~port_i.src_rx_a;
  wire slip_evt_w = (slip_a_ok_w & port_i.slip_a) | (slip_b_ok_w & port_i.slip_b);

  // Copy flag only while copies are enabled
  wire copy_evt_w = rx_evt_i.copy_done & ~buffer_copy_disable_i;

  // Sticky event set pulses per bit, index is the bit position
  logic [7:0] set_w;
  assign set_w[RXS_BIT_CS_CRC] = rx_evt_i.cs_crc_err;
  assign set_w[RXS_BIT_PARITY] = rx_evt_i.parity_err;
  assign set_w[RXS_BIT_VALIDITY] = 1'b0;
  assign set_w[RXS_BIT_BIPHASE] = rx_evt_i.biphase_err;
  assign set_w[RXS_BIT_SUBCODE_CHG] = rx_evt_i.subcode_new;
  assign set_w[RXS_BIT_UNLOCK] = 1'b0;
  assign set_w[RXS_BIT_SUBCODE_CRC] = rx_evt_i.subcode_crc_err;
  assign set_w[RXS_BIT_BUF_DONE] = copy_evt_w;

  // Reading the register clears the sticky flags
  logic [7:0] sticky_w;
  logic [7:0] sticky_irq_w;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      rxs_flag u_flag (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .set_i(set_w[gi]),
        .clr_i(rd_err_w),
        .mask_en_i(err_mask_q[gi]),
        .flag_o(sticky_w[gi]),
        .irq_o(sticky_irq_w[gi])
      );
    end
  endgenerate

  // Validity and unlock are live levels, the rest sticky
  logic [7:0] err_status_w;
  assign err_status_w = {sticky_w[7:6], rx_evt_i.validity, sticky_w[4:3], unlock_w, sticky_w[1:0]};

  // Slip flag
  logic slip_flag_w;
  logic slip_irq_w;
  rxs_flag u_slip (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .set_i(slip_evt_w),
    .clr_i(rd_slip_w),
    .mask_en_i(slip_mask_q),
    .flag_o(slip_flag_w),
    .irq_o(slip_irq_w)
  );

  // Gated interrupt terms; sticky bits come gated from their cells, live levels here
  wire [7:0] err_irq_w = {sticky_irq_w[7:6], rx_evt_i.validity & err_mask_q[RXS_BIT_VALIDITY], sticky_irq_w[4:3],
    unlock_w & err_mask_q[RXS_BIT_UNLOCK], sticky_irq_w[1:0]};
  wire slip_gated_w = slip_irq_w;
  wire irq_any_w = (|err_irq_w) | slip_gated_w;

  // Read data and interrupt from flip-flops
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_n_q;

  assign rdata_d = rd_err_w ? err_status_w :
                   rd_slip_w ? {7'h00, slip_flag_w} :
                   8'h00;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= RXS_RST_STATUS;
      irq_n_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      irq_n_q <= ~irq_any_w;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_n_o = irq_n_q;

  // Masks: reset value, write and hold
  AST_MASK_RESET: assert property (@(posedge ref_clk_i)
    $rose(nrst_i) |-> err_mask_q == 8'h00 && !slip_mask_q)
    else $error("mask not zero after reset");
  AST_MASK_WRITE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_err_mask_w |=> err_mask_q == $past(reg_wdata_i))
    else $error("error mask write lost");
  AST_MASK_HOLD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !wr_err_mask_w |=> $stable(err_mask_q))
    else $error("error mask changed without write");
  AST_SLIP_MASK_WRITE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_slip_mask_w |=> slip_mask_q == $past(reg_wdata_i[RXS_BIT_SLIP]))
    else $error("slip mask write lost");

  // Sticky error bits set on their event and clear on read
  AST_CS_CRC_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.cs_crc_err |=> sticky_w[RXS_BIT_CS_CRC])
    else $error("crc flag not set");
  AST_PARITY_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.parity_err |=> sticky_w[RXS_BIT_PARITY])
    else $error("parity flag not set");
  AST_BIPHASE_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.biphase_err |=> sticky_w[RXS_BIT_BIPHASE])
    else $error("biphase flag not set");
  AST_SUBCODE_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.subcode_new |=> sticky_w[RXS_BIT_SUBCODE_CHG])
    else $error("subcode change not set");
  AST_SUBCODE_CHECK_ERROR_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.subcode_crc_err |=> sticky_w[RXS_BIT_SUBCODE_CRC])
    else $error("subcode crc not set");
  AST_COPY_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.copy_done && !buffer_copy_disable_i |=> sticky_w[RXS_BIT_BUF_DONE])
    else $error("copy flag not set");
  AST_COPY_DIS: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    buffer_copy_disable_i && !sticky_w[RXS_BIT_BUF_DONE] |=> !sticky_w[RXS_BIT_BUF_DONE])
    else $error("copy flag set while disabled");
  AST_ERR_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> (sticky_w & ~$past(set_w)) == 8'h00)
    else $error("sticky flag survived read");

  // Read data carries the flag state of the read edge
  AST_VALID_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_VALIDITY] == $past(rx_evt_i.validity))
    else $error("validity read wrong");
  AST_CS_CRC_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_CS_CRC] == $past(sticky_w[RXS_BIT_CS_CRC]))
    else $error("crc flag read wrong");
  AST_PARITY_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_PARITY] == $past(sticky_w[RXS_BIT_PARITY]))
    else $error("parity flag read wrong");
  AST_BIPHASE_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_BIPHASE] == $past(sticky_w[RXS_BIT_BIPHASE]))
    else $error("biphase flag read wrong");
  AST_SUBCODE_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_SUBCODE_CHG] == $past(sticky_w[RXS_BIT_SUBCODE_CHG]))
    else $error("subcode change read wrong");
  AST_SUBCODE_CHECK_ERROR_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_SUBCODE_CRC] == $past(sticky_w[RXS_BIT_SUBCODE_CRC]))
    else $error("subcode crc read wrong");
  AST_COPY_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_BUF_DONE] == $past(sticky_w[RXS_BIT_BUF_DONE]))
    else $error("copy flag read wrong");
  AST_UNLOCK_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_err_w |=> reg_rdata_o[RXS_BIT_UNLOCK] == $past(unlock_w))
    else $error("unlock read wrong");

  // Lock tracking: two sync edges, then a live level
  AST_UNLOCK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (rx_evt_i.decoder_locked && rx_evt_i.pll_locked) [*3] |-> !unlock_w)
    else $error("unlock while locked");
  AST_UNLOCK_DEC: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!rx_evt_i.decoder_locked) [*3] |-> unlock_w)
    else $error("decoder unlock not reported");
  AST_UNLOCK_PLL: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!rx_evt_i.pll_locked) [*3] |-> unlock_w)
    else $error("loop unlock not reported");

  // Slip qualification and the slip register
  AST_SLIP_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    port_i.src_rx_a && port_i.slave_a && port_i.slip_a |=> slip_flag_w)
    else $error("slip not set");
  AST_SLIP_B_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    port_i.src_rx_b && port_i.slave_b && !port_i.src_rx_a && port_i.slip_b |=> slip_flag_w)
    else $error("port b slip not set");
  AST_SLIP_MASTER: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !slip_a_ok_w && !slip_b_ok_w && !slip_flag_w |=> !slip_flag_w)
    else $error("slip set without slave source");
  AST_SLIP_B_IGN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    port_i.src_rx_a |-> slip_evt_w == (port_i.slave_a && port_i.slip_a))
    else $error("port b slip tracked with port a sourced");
  AST_SLIP_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_slip_w && !slip_evt_w |=> !slip_flag_w)
    else $error("slip flag survived read");
  AST_SLIP_SETWIN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_slip_w && slip_evt_w |=> slip_flag_w)
    else $error("slip lost to read clear");
  AST_SLIP_RD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_slip_w |=> reg_rdata_o[RXS_BIT_SLIP] == $past(slip_flag_w))
    else $error("slip flag read wrong");
  AST_SLIP_ZERO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_slip_w |=> reg_rdata_o[7:1] == 7'h00)
    else $error("slip upper bits nonzero");

  // Interrupt request follows the unmasked flags
  AST_IRQ_MASKED: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (err_mask_q == 8'h00 && !slip_mask_q) |=> irq_n_o)
    else $error("irq while all masked");
  AST_ERR_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    sticky_w[RXS_BIT_PARITY] && err_mask_q[RXS_BIT_PARITY] |=> !irq_n_o)
    else $error("parity irq missing");
  AST_BIPHASE_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    sticky_w[RXS_BIT_BIPHASE] && err_mask_q[RXS_BIT_BIPHASE] |=> !irq_n_o)
    else $error("biphase irq missing");
  AST_VALID_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rx_evt_i.validity && err_mask_q[RXS_BIT_VALIDITY] |=> !irq_n_o)
    else $error("validity irq missing");
  AST_UNLOCK_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    unlock_w && err_mask_q[RXS_BIT_UNLOCK] |=> !irq_n_o)
    else $error("unlock irq missing");
  AST_SLIP_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    slip_flag_w && slip_mask_q |=> !irq_n_o)
    else $error("slip irq missing");
  AST_SLIP_MASKED: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    slip_flag_w && !slip_mask_q && (err_status_w & err_mask_q) == 8'h00 |=> irq_n_o)
    else $error("masked slip raised irq");
  AST_IRQ_RAISE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    irq_any_w |=> !irq_n_o)
    else $error("irq not raised");
  AST_IRQ_DROP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !irq_any_w |=> irq_n_o)
    else $error("irq held without source");

  // Main scenarios
  COV_ERR_IRQ: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) |err_irq_w ##1 !irq_n_o);
  COV_SLIP: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) slip_evt_w ##1 rd_slip_w);
  COV_CLEAR_RD: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) sticky_w[7] ##1 rd_err_w ##1 !sticky_w[7]);
  COV_UNLOCK: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $fell(unlock_w));
  COV_SLIP_B: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) slip_b_ok_w && port_i.slip_b ##1 slip_flag_w);

endmodule
`default_nettype wire

// file: test/test_rxs_status_top.sv
// Self-checking bench for the receiver error and slip status registers.
// Assumes the design's port contract: read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module test_rxs_status_top;
  import rxs_pkg::*;

  // Clock, reset and register port
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic irq_n_o;
  // Receiver pulses and levels, port config and slips
  logic [7:0] pl = 8'h00;
  logic vld = 1'b0;
  logic dlk = 1'b0;
  logic plk = 1'b0;
  logic copy_dis = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [1:0] slp = 2'h0;
  rxs_event_t rx_evt_i;
  rxs_port_t port_i;
  // Scoreboard
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int bits[6] = '{7, 6, 4, 3, 1, 0};
  logic [6:0] sl[5] = '{7'b1010101, 7'b1000100, 7'b0101011, 7'b1111010, 7'b0011110};
  logic [7:0] m;
  int b;
  int seed_v;

  always #25 ref_clk_i = ~ref_clk_i;

  // Pulse vector bit positions match the status register layout
  assign rx_evt_i = '{cs_crc_err: pl[7], parity_err: pl[6], validity: vld, biphase_err: pl[4],
    subcode_new: pl[3], decoder_locked: dlk, pll_locked: plk, subcode_crc_err: pl[1], copy_done: pl[0]};
  assign port_i = rxs_port_t'({cfg, slp});

  rxs_status_top u_rxs_status_top (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .reg_rd_i(reg_rd_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .rx_evt_i(rx_evt_i),
    .port_i(port_i),
    .buffer_copy_disable_i(copy_dis),
    .irq_n_o(irq_n_o)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] onehot(input int k);
    logic [7:0] v;
    v = 8'h00;
    v[k] = 1'b1;
    return v;
  endfunction

  // Read data stands one cycle, so compare mid-cycle after the taking edge
  always @(posedge ref_clk_i) rd_pend <= reg_rd_i;
  always @(negedge ref_clk_i) begin
    if (rd_pend && exp_q.size() > 0) begin
      check(reg_rdata_o, exp_q.pop_front(), "read data");
    end
  end

  // Every task starts just after a rising edge and ends just after one
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic pulse(input int k);
    pl <= onehot(k);
    @(posedge ref_clk_i);
    pl <= 8'h00;
    @(posedge ref_clk_i);
  endtask

  task automatic slip(input logic [1:0] v);
    slp <= v;
    @(posedge ref_clk_i);
    slp <= 2'h0;
    @(posedge ref_clk_i);
  endtask

  // Request is registered, so look at it away from the edge
  task automatic irq_is(input logic e);
    @(negedge ref_clk_i);
    check({7'h00, irq_n_o}, {7'h00, e}, "irq request");
    @(posedge ref_clk_i);
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    fail_count++;
    give_verdict();
  end

  initial begin
    seed_v = $urandom(4);
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_is(1'b1);
    rd(RXS_ADDR_ERR_STATUS, RXS_RST_LOCK_STATUS);
    rd(RXS_ADDR_SLIP_STATUS, 8'h00);
    rd(RXS_ADDR_ERR_MASK, 8'h00);
    rd(7'h30, 8'h00);
    // Lock needs both decoder and PLL; sync adds two edges
    dlk <= 1'b1;
    plk <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(RXS_ADDR_ERR_STATUS, 8'h00);
    plk <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rd(RXS_ADDR_ERR_STATUS, 8'h04);
    plk <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    // Each sticky flag sets alone and clears on read
    for (int i = 0; i < 6; i++) begin
      pulse(bits[i]);
      rd(RXS_ADDR_ERR_STATUS, onehot(bits[i]));
      rd(RXS_ADDR_ERR_STATUS, 8'h00);
    end
    vld <= 1'b1;
    @(posedge ref_clk_i);
    rd(RXS_ADDR_ERR_STATUS, 8'h20);
    rd(RXS_ADDR_ERR_STATUS, 8'h20);
    vld <= 1'b0;
    copy_dis <= 1'b1;
    pulse(0);
    rd(RXS_ADDR_ERR_STATUS, 8'h00);
    copy_dis <= 1'b0;
    wr(RXS_ADDR_ERR_STATUS, 8'hff);
    rd(RXS_ADDR_ERR_STATUS, 8'h00);
    // Masked flag must not request, random masks gate a randomly picked sticky flag
    pulse(6);
    irq_is(1'b1);
    rd(RXS_ADDR_ERR_STATUS, 8'h40);
    for (int k = 0; k < 8; k++) begin
      m = 8'($urandom);
      b = bits[$urandom_range(5, 0)];
      wr(RXS_ADDR_ERR_MASK, m);
      pulse(b);
      irq_is(!m[b]);
      rd(RXS_ADDR_ERR_STATUS, onehot(b));
      irq_is(1'b1);
    end
    // Live levels request too once their mask bit is set
    wr(RXS_ADDR_ERR_MASK, 8'h24);
    vld <= 1'b1;
    @(posedge ref_clk_i);
    irq_is(1'b0);
    vld <= 1'b0;
    @(posedge ref_clk_i);
    irq_is(1'b1);
    plk <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    irq_is(1'b0);
    plk <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    irq_is(1'b1);
    // Slip only from a receiver-fed slave port, port A first
    for (int i = 0; i < 5; i++) begin
      cfg <= sl[i][6:3];
      @(posedge ref_clk_i);
      slip(sl[i][2:1]);
      rd(RXS_ADDR_SLIP_STATUS, {7'h00, sl[i][0]});
    end
    cfg <= 4'b1010;
    slip(2'b10);
    irq_is(1'b1);
    rd(RXS_ADDR_SLIP_STATUS, 8'h01);
    wr(RXS_ADDR_SLIP_MASK, 8'h01);
    slip(2'b10);
    irq_is(1'b0);
    rd(RXS_ADDR_SLIP_STATUS, 8'h01);
    irq_is(1'b1);
    // Mid-run reset drops the masks and restarts lock tracking
    nrst_i <= 1'b0;
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(RXS_ADDR_ERR_STATUS, RXS_RST_LOCK_STATUS);
    slip(2'b10);
    irq_is(1'b1);
    rd(RXS_ADDR_SLIP_STATUS, 8'h01);
    repeat (2) @(posedge ref_clk_i);
    give_verdict();
  end
endmodule
`default_nettype wire
